// ===== logic/rvm_pkg.sv
// Purpose: Constants for the regulator voltage monitor block.
// Assumes: 250 MHz system clock, APB register access, four buck channels.
// Notes: Debounce and settling times run on a 1 us internal tick.
//
// Functional notes
// - Low and high supervision on four channels.
// - Low level code selects 95/93/91/89 percent.
// - High level code selects 105/107/109/111 percent.
// - Low filter code selects 5/15/30/40 us.
// - Low filter code resets to binary 10.
// - Shared high filter selects 30/50/80/125 us.
// - High filter code resets to binary 00.
// - Per-channel enable gates both supervisions.
// - All channel enables reset to one.
// - Guard set requires secure sequence for enables.
// - Fault reporting masked until regulation reached.
// - Disabled monitor forces both states to zero.
// - Comparators ignored during 30 us settling.
package rvm_pkg;
   localparam int          CLK_PERIOD_NS   = 4;
   localparam int          TICK_PERIOD_NS  = 1000;
   localparam int          TICK_CYCLES     = TICK_PERIOD_NS / CLK_PERIOD_NS;
   localparam int          SETTLE_TIME_US  = 30;
   localparam int          SETTLE_TICKS    = (SETTLE_TIME_US * 1000) / TICK_PERIOD_NS;
   localparam int          LOW_DB_US0      = 5;
   localparam int          LOW_DB_US1      = 15;
   localparam int          LOW_DB_US2      = 30;
   localparam int          LOW_DB_US3      = 40;
   localparam int          HIGH_DB_US0     = 30;
   localparam int          HIGH_DB_US1     = 50;
   localparam int          HIGH_DB_US2     = 80;
   localparam int          HIGH_DB_US3     = 125;
   localparam int          NUM_CHANNELS    = 4;
   localparam logic [7:0]  ADDR_MON_EN     = 8'h00;
   localparam logic [7:0]  ADDR_LEVEL      = 8'h04;
   localparam logic [7:0]  ADDR_FILTER     = 8'h08;
   localparam logic [7:0]  ADDR_CTRL       = 8'h0C;
   localparam logic [7:0]  ADDR_KEY        = 8'h10;
   localparam logic [7:0]  ADDR_STATE      = 8'h14;
   localparam logic [7:0]  ADDR_IRQ_STAT   = 8'h18;
   localparam logic [7:0]  ADDR_IRQ_MASK   = 8'h1C;
   localparam int          LEVEL_HIGH_POS  = 8;
   localparam int          FILT_LOW_POS    = 0;
   localparam int          FILT_HIGH_POS   = 2;
   localparam int          CTRL_GUARD_POS  = 0;
   localparam int          STATE_HIGH_POS  = 4;
   localparam logic [3:0]  MON_EN_RESET    = 4'hF;
   localparam logic [1:0]  LOW_FILT_RESET  = 2'h2;
   localparam logic [1:0]  HIGH_FILT_RESET = 2'h0;
   localparam logic [31:0] SECURE_KEY_DEF  = 32'h5A5AC3C3;
endpackage : rvm_pkg

// ===== logic/rvm_monitor.sv
// Purpose: Over- and under-voltage supervision control for four buck channels.
// Assumes: Comparator, regulator-on and in-regulation inputs are synchronous to clk.
// Notes: Registers are reached over APB; every output is a flip-flop.
`timescale 1ns/1ps
`default_nettype none
module rvm_monitor
   import rvm_pkg::*;
#(
   parameter int          TICK_CYC   = TICK_CYCLES,
   parameter logic [31:0] SECURE_KEY = SECURE_KEY_DEF
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        ce,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [3:0]  low_fault_raw,
   input  wire logic [3:0]  high_fault_raw,
   input  wire logic [3:0]  reg_on,
   input  wire logic [3:0]  reg_in_regulation,
   output logic      [3:0]  channel_monitor_enable,
   output logic      [7:0]  low_limit_level_code,
   output logic      [7:0]  high_limit_level_code,
   output logic      [3:0]  low_limit_state,
   output logic      [3:0]  high_limit_state,
   output logic             irq
);

   // The tick divider is 16 bits wide and needs at least two states.
   if (TICK_CYC < 2 || TICK_CYC > 65535) begin : g_tick_check
      $error("TICK_CYC out of range");
   end

   // Debounce length in ticks for a filter code; the tick is the slow timebase.
   function automatic logic [7:0] filt_ticks(input logic high, input logic [1:0] code);
      int us;
      us = 0;
      if (!high) begin
         case (code)
            2'h0: us = LOW_DB_US0;
            2'h1: us = LOW_DB_US1;
            2'h2: us = LOW_DB_US2;
            default: us = LOW_DB_US3;
         endcase
      end else begin
         case (code)
            2'h0: us = HIGH_DB_US0;
            2'h1: us = HIGH_DB_US1;
            2'h2: us = HIGH_DB_US2;
            default: us = HIGH_DB_US3;
         endcase
      end
      return 8'((us * 1000) / TICK_PERIOD_NS);
   endfunction

   typedef enum logic [1:0] {RVM_IDLE, RVM_ACCESS, RVM_DONE} rvm_phase_e;

   // Register and bus state.
   rvm_phase_e  phase_q,   phase_d;
   logic [31:0] prdata_q,  prdata_d;
   logic        pready_q,  pready_d;
   logic        pslverr_q, pslverr_d;
   logic [3:0]  en_q,      en_d;
   logic [7:0]  lvl_lo_q,  lvl_lo_d;
   logic [7:0]  lvl_hi_q,  lvl_hi_d;
   logic [1:0]  flt_lo_q,  flt_lo_d;
   logic [1:0]  flt_hi_q,  flt_hi_d;
   logic        guard_q,   guard_d;
   logic        armed_q,   armed_d;
   logic [7:0]  ist_q,     ist_d;
   logic [7:0]  imask_q,   imask_d;
   logic        irq_q,     irq_d;

   // Monitor state.
   logic [15:0] tdiv_q,    tdiv_d;
   logic        tick;
   logic [3:0]  en_old_q,  en_old_d;
   logic [3:0]  on_old_q,  on_old_d;
   logic [3:0]  blank_q,   blank_d;
   logic [7:0]  settle_q [NUM_CHANNELS];
   logic [7:0]  settle_d [NUM_CHANNELS];
   logic [7:0]  cnt_lo_q [NUM_CHANNELS];
   logic [7:0]  cnt_lo_d [NUM_CHANNELS];
   logic [7:0]  cnt_hi_q [NUM_CHANNELS];
   logic [7:0]  cnt_hi_d [NUM_CHANNELS];
   logic [3:0]  st_lo_q,   st_lo_d;
   logic [3:0]  st_hi_q,   st_hi_d;

   logic        wr_fire;
   logic        rd_fire;
   logic [7:0]  st_rise;

   assign wr_fire = (phase_q == RVM_ACCESS) && psel && penable && pready_q && pwrite;
   assign rd_fire = (phase_q == RVM_ACCESS) && psel && penable && pready_q && !pwrite;
   assign tick    = (tdiv_q == 16'(TICK_CYC - 1));
   assign st_rise = {st_hi_d & ~st_hi_q, st_lo_d & ~st_lo_q};

   always_comb begin
      phase_d   = phase_q;
      prdata_d  = prdata_q;
      pready_d  = 1'b0;
      pslverr_d = 1'b0;
      en_d      = en_q;
      lvl_lo_d  = lvl_lo_q;
      lvl_hi_d  = lvl_hi_q;
      flt_lo_d  = flt_lo_q;
      flt_hi_d  = flt_hi_q;
      guard_d   = guard_q;
      armed_d   = armed_q;
      imask_d   = imask_q;
      ist_d     = ist_q;
      // A one cycle wait in the access phase lets read data come from a flop.
      case (phase_q)
         RVM_IDLE: begin
            if (psel && !penable) begin
               phase_d = RVM_ACCESS;
            end
         end
         RVM_ACCESS: begin
            if (psel && penable && !pready_q) begin
               pready_d  = 1'b1;
               prdata_d  = 32'h0;
               pslverr_d = 1'b0;
               if (paddr == ADDR_MON_EN) begin
                  prdata_d[3:0] = en_q;
               end else if (paddr == ADDR_LEVEL) begin
                  prdata_d[15:0] = {lvl_hi_q, lvl_lo_q};
               end else if (paddr == ADDR_FILTER) begin
                  prdata_d[3:0] = {flt_hi_q, flt_lo_q};
               end else if (paddr == ADDR_CTRL) begin
                  prdata_d[CTRL_GUARD_POS] = guard_q;
               end else if (paddr == ADDR_KEY) begin
                  prdata_d[0] = armed_q;
               end else if (paddr == ADDR_STATE) begin
                  prdata_d[7:0] = {st_hi_q, st_lo_q};
               end else if (paddr == ADDR_IRQ_STAT) begin
                  prdata_d[7:0] = ist_q;
               end else if (paddr == ADDR_IRQ_MASK) begin
                  prdata_d[7:0] = imask_q;
               end else begin
                  pslverr_d = 1'b1;
               end
            end else if (pready_q) begin
               phase_d = RVM_IDLE;
            end
         end
         default: phase_d = RVM_IDLE;
      endcase
      if (wr_fire) begin
         // Any write other than the key, the enables included, drops a pending unlock.
         armed_d = 1'b0;
         if (paddr == ADDR_MON_EN) begin
            if (!guard_q || armed_q) begin
               en_d = pwdata[3:0];
            end
         end else if (paddr == ADDR_LEVEL) begin
            lvl_lo_d = pwdata[7:0];
            lvl_hi_d = pwdata[LEVEL_HIGH_POS +: 8];
         end else if (paddr == ADDR_FILTER) begin
            flt_lo_d = pwdata[FILT_LOW_POS +: 2];
            flt_hi_d = pwdata[FILT_HIGH_POS +: 2];
         end else if (paddr == ADDR_CTRL) begin
            guard_d = pwdata[CTRL_GUARD_POS];
         end else if (paddr == ADDR_KEY) begin
            armed_d = (pwdata == SECURE_KEY);
         end else if (paddr == ADDR_IRQ_MASK) begin
            imask_d = pwdata[7:0];
         end
      end
      // Set wins over a write-one clear in the same cycle.
      if (wr_fire && paddr == ADDR_IRQ_STAT) begin
         ist_d = ist_q & ~pwdata[7:0];
      end
      ist_d = ist_d | st_rise;
      irq_d = |(ist_d & imask_d);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         phase_q   <= RVM_IDLE;
         prdata_q  <= 32'h0;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         en_q      <= MON_EN_RESET;
         lvl_lo_q  <= 8'h0;
         lvl_hi_q  <= 8'h0;
         flt_lo_q  <= LOW_FILT_RESET;
         flt_hi_q  <= HIGH_FILT_RESET;
         guard_q   <= 1'b0;
         armed_q   <= 1'b0;
         ist_q     <= 8'h0;
         imask_q   <= 8'h0;
         irq_q     <= 1'b0;
      end else if (ce) begin
         phase_q   <= phase_d;
         prdata_q  <= prdata_d;
         pready_q  <= pready_d;
         pslverr_q <= pslverr_d;
         en_q      <= en_d;
         lvl_lo_q  <= lvl_lo_d;
         lvl_hi_q  <= lvl_hi_d;
         flt_lo_q  <= flt_lo_d;
         flt_hi_q  <= flt_hi_d;
         guard_q   <= guard_d;
         armed_q   <= armed_d;
         ist_q     <= ist_d;
         imask_q   <= imask_d;
         irq_q     <= irq_d;
      end
   end

   always_comb begin
      logic       active;
      logic [7:0] lo_term;
      logic [7:0] hi_term;
      active   = 1'b0;
      lo_term  = filt_ticks(1'b0, flt_lo_q);
      hi_term  = filt_ticks(1'b1, flt_hi_q);
      tdiv_d   = tick ? 16'h0 : tdiv_q + 16'h1;
      en_old_d = en_q;
      on_old_d = reg_on;
      blank_d  = blank_q;
      st_lo_d  = st_lo_q;
      st_hi_d  = st_hi_q;
      for (int i = 0; i < NUM_CHANNELS; i++) begin
         settle_d[i] = settle_q[i];
         cnt_lo_d[i] = cnt_lo_q[i];
         cnt_hi_d[i] = cnt_hi_q[i];
         // Blank from switch-on until the regulator reports regulation.
         if (reg_on[i] && !on_old_q[i]) begin
            blank_d[i] = 1'b1;
         end else if (reg_in_regulation[i] || !reg_on[i]) begin
            blank_d[i] = 1'b0;
         end
         // Counting whole ticks may settle up to one tick early, never late.
         if (en_q[i] && !en_old_q[i]) begin
            settle_d[i] = 8'(SETTLE_TICKS);
         end else if (tick && settle_q[i] != 8'h0) begin
            settle_d[i] = settle_q[i] - 8'h1;
         end
         active = en_q[i] && en_old_q[i] && reg_on[i] && on_old_q[i] && !blank_q[i] &&
                  (settle_q[i] == 8'h0);
         if (!active || !low_fault_raw[i]) begin
            cnt_lo_d[i] = 8'h0;
         end else if (tick && cnt_lo_q[i] < lo_term) begin
            cnt_lo_d[i] = cnt_lo_q[i] + 8'h1;
         end
         if (!active || !high_fault_raw[i]) begin
            cnt_hi_d[i] = 8'h0;
         end else if (tick && cnt_hi_q[i] < hi_term) begin
            cnt_hi_d[i] = cnt_hi_q[i] + 8'h1;
         end
         st_lo_d[i] = active && low_fault_raw[i] && (cnt_lo_q[i] >= lo_term);
         st_hi_d[i] = active && high_fault_raw[i] && (cnt_hi_q[i] >= hi_term);
         if (!en_q[i]) begin
            st_lo_d[i] = 1'b0;
            st_hi_d[i] = 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         tdiv_q   <= 16'h0;
         en_old_q <= 4'h0;
         on_old_q <= 4'h0;
         blank_q  <= 4'h0;
         st_lo_q  <= 4'h0;
         st_hi_q  <= 4'h0;
         for (int i = 0; i < NUM_CHANNELS; i++) begin
            settle_q[i] <= 8'h0;
            cnt_lo_q[i] <= 8'h0;
            cnt_hi_q[i] <= 8'h0;
         end
      end else if (ce) begin
         tdiv_q   <= tdiv_d;
         en_old_q <= en_old_d;
         on_old_q <= on_old_d;
         blank_q  <= blank_d;
         st_lo_q  <= st_lo_d;
         st_hi_q  <= st_hi_d;
         for (int i = 0; i < NUM_CHANNELS; i++) begin
            settle_q[i] <= settle_d[i];
            cnt_lo_q[i] <= cnt_lo_d[i];
            cnt_hi_q[i] <= cnt_hi_d[i];
         end
      end
   end

   assign prdata                 = prdata_q;
   assign pready                 = pready_q;
   assign pslverr                = pslverr_q;
   assign channel_monitor_enable = en_q;
   assign low_limit_level_code   = lvl_lo_q;
   assign high_limit_level_code  = lvl_hi_q;
   assign low_limit_state        = st_lo_q;
   assign high_limit_state       = st_hi_q;
   assign irq                    = irq_q;

endmodule : rvm_monitor
`default_nettype wire

// ===== tb/rvm_comp_model.sv
// Purpose: Regulator and comparator model for the four buck channels.
// Assumes: Commands from the bench arrive on clock edges.
// Notes: A ramping regulator reads as low, which the blanking must hide.
`timescale 1ns/1ps
`default_nettype none
module rvm_comp_model #(
   parameter int RAMP = 200
) (
   input  wire logic       clk,
   input  wire logic [3:0] power_up,
   input  wire logic [3:0] low_cmd,
   input  wire logic [3:0] high_cmd,
   output var logic  [3:0] reg_on,
   output var logic  [3:0] reg_in_regulation,
   output logic      [3:0] low_fault_raw,
   output logic      [3:0] high_fault_raw
);
   int cnt [4] = '{0, 0, 0, 0};
   initial reg_on = 4'h0;
   initial reg_in_regulation = 4'h0;
   always @(posedge clk) begin
      for (int i = 0; i < 4; i++) begin
         reg_on[i] <= power_up[i];
         cnt[i] <= !power_up[i] ? 0 : (cnt[i] < RAMP) ? cnt[i] + 1 : cnt[i];
         reg_in_regulation[i] <= (cnt[i] == RAMP);
      end
   end
   // Output still below the trip point until the ramp completes.
   assign low_fault_raw  = low_cmd | (reg_on & ~reg_in_regulation);
   assign high_fault_raw = high_cmd & reg_on;
endmodule // rvm_comp_model
`default_nettype wire

// ===== tb/rvm_monitor_asserts.sv
// Purpose: Port checker for the voltage monitor.
// Assumes: Clock enable is low only while the bus is idle.
// Notes: Debounce floors allow one tick of phase slip.
`timescale 1ns/1ps
`default_nettype none
module rvm_monitor_asserts
   import rvm_pkg::*;
#(
   parameter int TICK_CYC = TICK_CYCLES
) (
   input wire logic       clk,
   input wire logic       rst,
   input wire logic       psel,
   input wire logic       penable,
   input wire logic       pwrite,
   input wire logic [7:0] paddr,
   input wire logic       pready,
   input wire logic       pslverr,
   input wire logic [3:0] low_fault_raw,
   input wire logic [3:0] high_fault_raw,
   input wire logic [3:0] reg_on,
   input wire logic [3:0] channel_monitor_enable,
   input wire logic [3:0] low_limit_state,
   input wire logic [3:0] high_limit_state
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   int lo_run = 0;
   int hi_run = 0;
   always_ff @(posedge clk) begin
      lo_run <= low_fault_raw[0] ? lo_run + 1 : 0;
      hi_run <= high_fault_raw[0] ? hi_run + 1 : 0;
   end
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_answer;
      (penable && !pready) ##1 (penable && pready);
   endsequence
   a_apb_wait_state: assert property (s_setup |=> s_answer)
      else $error("APB answer not after one wait state");
   a_pready_pulse: assert property (pready |=> !pready)
      else $error("pready held longer than one cycle");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_enable_by_write: assert property ($changed(channel_monitor_enable) |->
      $past(pready && pwrite && paddr == ADDR_MON_EN))
      else $error("enable changed without a bus write");
   a_off_clears_state: assert property (((low_limit_state | high_limit_state) &
      ~(channel_monitor_enable | $past(channel_monitor_enable))) == 4'h0)
      else $error("state set on a disabled channel");
   a_rise_needs_on: assert property ((((low_limit_state & ~$past(low_limit_state)) |
      (high_limit_state & ~$past(high_limit_state))) & ~(channel_monitor_enable & reg_on)) == 4'h0)
      else $error("state rose on an inactive channel");
   a_drop_follows_raw: assert property ((low_limit_state &
      ~($past(low_fault_raw) | $past(low_fault_raw, 2))) == 4'h0)
      else $error("low state stayed after the fault ended");
   a_low_floor: assert property ($rose(low_limit_state[0]) |-> lo_run >= 4 * TICK_CYC - 2)
      else $error("low state rose before the shortest filter");
   a_high_floor: assert property ($rose(high_limit_state[0]) |-> hi_run >= 29 * TICK_CYC - 2)
      else $error("high state rose before the shortest filter");
   a_reset_values: assert property ($fell(rst) |-> channel_monitor_enable == MON_EN_RESET &&
      low_limit_state == 4'h0 && high_limit_state == 4'h0)
      else $error("outputs wrong after reset");
endmodule // rvm_monitor_asserts
bind rvm_monitor rvm_monitor_asserts #(.TICK_CYC(TICK_CYC)) rvm_monitor_asserts_i (.clk, .rst,
   .psel, .penable, .pwrite, .paddr, .pready, .pslverr, .low_fault_raw, .high_fault_raw,
   .reg_on, .channel_monitor_enable, .low_limit_state, .high_limit_state);
`default_nettype wire

// ===== tb/tb_top.sv
// Purpose: Register level bench for the voltage monitor.
// Assumes: Tick shortened to four clocks.
// Notes: Bus reads take the value at the edge that sees pready.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import rvm_pkg::*;
   localparam int TC = 4;
   logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq, err;
   logic        ce = 1;
   logic [7:0]  paddr = 0, low_limit_level_code, high_limit_level_code;
   logic [31:0] pwdata = 0, prdata, rd;
   logic [3:0]  low_fault_raw, high_fault_raw, reg_on, reg_in_regulation, channel_monitor_enable;
   logic [3:0]  low_limit_state, high_limit_state, pwr = 4'hF, lo_cmd = 0, hi_cmd = 0;
   int          bad_count = 0, compares = 0, cyc = 0;
   int          lo_t [4] = '{LOW_DB_US0, LOW_DB_US1, LOW_DB_US2, LOW_DB_US3};
   int          hi_t [4] = '{HIGH_DB_US0, HIGH_DB_US1, HIGH_DB_US2, HIGH_DB_US3};
   always #2 clk = ~clk;
   rvm_monitor #(.TICK_CYC(TC)) rvm_monitor_i (.clk, .rst, .ce, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .low_fault_raw, .high_fault_raw, .reg_on,
      .reg_in_regulation, .channel_monitor_enable, .low_limit_level_code,
      .high_limit_level_code, .low_limit_state, .high_limit_state, .irq);
   rvm_comp_model rvm_comp_model_i (.clk, .power_up(pwr), .low_cmd(lo_cmd), .high_cmd(hi_cmd),
      .reg_on, .reg_in_regulation, .low_fault_raw, .high_fault_raw);
   task automatic stop_test;
      $display("compares=%0d bad_count=%0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   task automatic setc(input logic hi, input logic v);
      if (hi) hi_cmd <= {3'h0, v};
      else lo_cmd <= {3'h0, v};
   endtask
   // Hold, break, hold again: a counter that ignores the break trips early.
   task automatic dbn(input logic hi, input int n);
      setc(hi, 1'b1);
      repeat ((n - 1) * TC) @(posedge clk);
      setc(hi, 1'b0);
      repeat (2) @(posedge clk);
      setc(hi, 1'b1);
      repeat ((n - 1) * TC) @(posedge clk);
      chk(32'(hi ? high_limit_state[0] : low_limit_state[0]), 32'h0);
      repeat (2 * TC + 4) @(posedge clk);
      chk(32'(hi ? high_limit_state[0] : low_limit_state[0]), 32'h1);
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         stop_test();
      end
   end
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      repeat (400) @(posedge clk);
      rdc(ADDR_MON_EN, 32'hF);
      rdc(ADDR_FILTER, 32'h2);
      rdc(ADDR_STATE, 32'h0);
      apb(1'b0, 8'h20, 32'h0);
      chk(32'(err), 32'h1);
      $display("test reset done");
      for (int c = 0; c < 4; c++) begin
         apb(1'b1, ADDR_LEVEL, {16'h0, 8'((3 - c) * 8'h55), 8'(c * 8'h55)});
         chk(32'(low_limit_level_code), 32'(c * 8'h55));
         chk(32'(high_limit_level_code), 32'((3 - c) * 8'h55));
      end
      $display("test levels done");
      apb(1'b1, ADDR_IRQ_MASK, 32'h1);
      for (int c = 0; c < 4; c++) begin
         apb(1'b1, ADDR_FILTER, 32'(c));
         dbn(1'b0, lo_t[c]);
         chk(32'(irq), 32'h1);
         lo_cmd <= 4'h0;
         apb(1'b1, ADDR_IRQ_STAT, 32'h1);
         chk(32'({irq, low_limit_state[0]}), 32'h0);
      end
      $display("test low filter done");
      apb(1'b1, ADDR_IRQ_MASK, 32'h0);
      for (int c = 0; c < 4; c++) begin
         apb(1'b1, ADDR_FILTER, 32'(c << FILT_HIGH_POS));
         dbn(1'b1, hi_t[c]);
         chk(32'(irq), 32'h0);
         hi_cmd <= 4'h0;
         repeat (3) @(posedge clk);
      end
      apb(1'b1, ADDR_IRQ_MASK, 32'h10);
      chk(32'(irq), 32'h1);
      apb(1'b1, ADDR_IRQ_STAT, 32'h10);
      chk(32'(irq), 32'h0);
      $display("test high filter done");
      lo_cmd <= 4'h1;
      repeat (7 * TC + 4) @(posedge clk);
      chk(32'(low_limit_state[0]), 32'h1);
      apb(1'b1, ADDR_CTRL, 32'h1);
      apb(1'b1, ADDR_MON_EN, 32'hE);
      rdc(ADDR_MON_EN, 32'hF);
      apb(1'b1, ADDR_KEY, SECURE_KEY_DEF);
      apb(1'b1, ADDR_MON_EN, 32'hE);
      chk(32'(channel_monitor_enable), 32'hE);
      @(posedge clk);
      chk(32'(low_limit_state[0]), 32'h0);
      apb(1'b1, ADDR_KEY, SECURE_KEY_DEF);
      apb(1'b1, ADDR_MON_EN, 32'hF);
      repeat (25 * TC) @(posedge clk);
      chk(32'(low_limit_state[0]), 32'h0);
      lo_cmd <= 4'h0;
      $display("test enable done");
      pwr <= 4'hD;
      repeat (4) @(posedge clk);
      pwr <= 4'hF;
      repeat (190) @(posedge clk);
      chk(32'({low_fault_raw[1], low_limit_state[1]}), 32'h2);
      $display("test blanking done");
      ce <= 1'b0;
      lo_cmd <= 4'h1;
      repeat (10 * TC) @(posedge clk);
      chk(32'(low_limit_state[0]), 32'h0);
      ce <= 1'b1;
      repeat (7 * TC + 4) @(posedge clk);
      chk(32'(low_limit_state[0]), 32'h1);
      $display("test clock enable done");
      stop_test();
   end
endmodule // tb_top
`default_nettype wire
